/* File: verif/cfg_writer_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cfg_writer_model
(
   input wire logic clock,
   output logic eeprom_wr_en,
   output logic smbus_wr_en,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data
);
   initial
   begin
      eeprom_wr_en = 1'b0;
      smbus_wr_en = 1'b0;
      wr_addr = 8'h00;
      wr_data = 8'h00;
   end
   // one byte per strobe; the bus is inverted once released so that a
   // stale address or data byte can never pass for a held one; an idle
   // edge follows each strobe so no signal is set twice in one step
   task automatic send(input logic ee, input logic [7:0] a,
                       input logic [7:0] d);
      eeprom_wr_en = ee;
      smbus_wr_en = !ee;
      wr_addr = a;
      wr_data = (a == hub_cfg_pkg::DEVICE_CONFIG_OFFSET) ? (d | 8'h18) : d;
      @(posedge clock);
      #1;
      eeprom_wr_en = 1'b0;
      smbus_wr_en = 1'b0;
      wr_addr = ~wr_addr;
      wr_data = ~wr_data;
      @(posedge clock);
      #1;
   endtask
endmodule
`default_nettype wire

/* File: verif/hub_device_config_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
module hub_device_config_regs_test;
   logic clock, rst, ee_m, sm_m, sd, pm, fe, dis, eld, hcd;
   logic ee_wr, sm_wr, b7, ser, blk, ind, gang, pwr, u12;
   logic st_ee, st_h, sn_ee, sn_h, sig, conn;
   logic [7:0] wa, wd, rd_addr, rd_data, pid, d1, d2;
   logic [31:0] seed;
   int mismatches, checked, cycles;
   cfg_writer_model host (.clock(clock), .eeprom_wr_en(ee_wr),
      .smbus_wr_en(sm_wr), .wr_addr(wa), .wr_data(wd));
   hub_device_config_regs uut (.clock(clock), .rst(rst),
      .eeprom_mode(ee_m), .smbus_mode(sm_m), .serial_data_strap_pin(sd),
      .power_mgmt_address_strap_pin(pm), .eeprom_wr_en(ee_wr),
      .smbus_wr_en(sm_wr), .wr_addr(wa), .wr_data(wd), .rd_addr(rd_addr),
      .force_lpm_event(fe), .upstream_disconnect(dis),
      .eeprom_load_done(eld), .host_cfg_done(hcd), .rd_data(rd_data),
      .product_id_high_byte(pid), .load_user_text_enable(b7),
      .user_serial_enable(ser), .low_power_link_state_block(blk),
      .port_indicator_setting(ind), .ganged_power_setting(gang),
      .per_port_power_control_n(pwr), .u1u2_permitted(u12),
      .string_eeprom_load(st_ee), .string_host_write(st_h),
      .serial_eeprom_load(sn_ee), .serial_host_write(sn_h),
      .signature_valid(sig), .upstream_connect_allow(conn));
   always #50 clock = ~clock;
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [7:0] cfg_exp(input logic a, c, e);
      return {a, 1'b1, c, 2'b11, e, 2'b00};
   endfunction
   task automatic close_out;
      if (mismatches == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic cmp8(input string n, input logic [7:0] e,
                       input logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cmp1(input string n, input logic e, input logic g);
      cmp8(n, {7'h00, e}, {7'h00, g});
   endtask
   task automatic tick;
      @(posedge clock);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rd_addr = a;
      tick;
      cmp8("rd_data", e, rd_data);
   endtask
   // straps stay put through the first cycle after release
   task automatic do_reset(input logic ee, input logic sm);
      ee_m = ee;
      sm_m = sm;
      seed = lfsr(seed);
      sd = seed[3];
      pm = seed[9];
      rst = 1'b1;
      repeat (20) tick;
      rst = 1'b0;
      tick;
      cmp1("link_block", sd, blk);
      cmp1("power_ctrl_n", pm, pwr);
      tick;
      cmp1("u1u2", !sd, u12);
      cmp1("serial_on", 1'b1, ser);
      cmp1("indicator", 1'b1, ind);
      cmp1("ganged", 1'b1, gang);
      cmp1("text_on", 1'b0, b7);
      cmp1("connect", !(ee | sm), conn);
      rd(8'h04, hub_cfg_pkg::PRODUCT_ID_HIGH_RESET);
      rd(8'h05, cfg_exp(1'b0, sd, pm));
   endtask
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         mismatches++;
         close_out;
      end
   end
   initial
   begin
      {clock, ee_m, sm_m, sd, pm, fe, dis, eld, hcd} = 9'h000;
      rst = 1'b1;
      rd_addr = 8'h00;
      seed = 32'h9005;
      do_reset(1'b0, 1'b0);
      host.send(1'b0, 8'h04, 8'h33);
      host.send(1'b1, 8'h05, 8'hA4);
      rd(8'h04, hub_cfg_pkg::PRODUCT_ID_HIGH_RESET);
      rd(8'h05, cfg_exp(1'b0, sd, pm));
      rd(8'h06, 8'h00);
      do_reset(1'b1, 1'b0);
      host.send(1'b1, 8'h00, 8'h55);
      cmp1("signature", 1'b1, sig);
      seed = lfsr(seed);
      d1 = seed[7:0];
      d2 = seed[15:8];
      host.send(1'b1, 8'h04, d1);
      host.send(1'b1, 8'h05, d2);
      cmp8("product", d1, pid);
      tick;
      cmp1("string_ee", d2[7], st_ee);
      cmp1("serial_ee", 1'b1, sn_ee);
      cmp1("u1u2", !d2[5], u12);
      rd(8'h05, cfg_exp(d2[7], d2[5], d2[2]));
      cmp1("connect", 1'b0, conn);
      eld = 1'b1;
      tick;
      eld = 1'b0;
      cmp1("connect", 1'b1, conn);
      host.send(1'b1, 8'h04, ~d1);
      rd(8'h04, d1);
      // corner: signature mismatch keeps defaults and ends the load
      do_reset(1'b1, 1'b0);
      host.send(1'b1, 8'h00, 8'h54);
      cmp1("signature", 1'b0, sig);
      tick;
      tick;
      cmp1("connect", 1'b1, conn);
      host.send(1'b1, 8'h05, 8'hA4);
      rd(8'h05, cfg_exp(1'b0, sd, pm));
      do_reset(1'b0, 1'b1);
      repeat (3) tick;
      cmp1("connect", 1'b0, conn);
      seed = lfsr(seed);
      d2 = seed[7:0] | 8'h20;
      host.send(1'b0, 8'h05, d2);
      tick;
      cmp1("u1u2", 1'b0, u12);
      cmp1("string_host", d2[7], st_h);
      cmp1("serial_host", 1'b1, sn_h);
      fe = 1'b1;
      tick;
      fe = 1'b0;
      cmp1("u1u2", 1'b1, u12);
      host.send(1'b0, 8'h05, d2);
      tick;
      cmp1("u1u2", 1'b1, u12);
      dis = 1'b1;
      tick;
      dis = 1'b0;
      cmp1("u1u2", 1'b0, u12);
      fe = 1'b1;
      dis = 1'b1;
      tick;
      fe = 1'b0;
      dis = 1'b0;
      cmp1("u1u2", 1'b1, u12);
      hcd = 1'b1;
      tick;
      hcd = 1'b0;
      cmp1("connect", 1'b1, conn);
      host.send(1'b0, 8'h04, d1);
      cmp8("product", d1, pid);
      rd(8'h05, cfg_exp(d2[7], 1'b1, d2[2]));
      // a fresh reset must drop the forced link state permission
      do_reset(1'b0, 1'b1);
      close_out;
   end
endmodule
`default_nettype wire

/* File: verilog/config_field_cell.sv */
`timescale 1ns/1ps
`default_nettype none
module config_field_cell
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic load_strap,
   input wire logic [WIDTH-1:0] strap_value,
   input wire logic write_en,
   input wire logic [WIDTH-1:0] write_value,
   output logic [WIDTH-1:0] value
);
   logic [WIDTH-1:0] value_reg;
   logic [WIDTH-1:0] value_next;

   // a write in the strap cycle is later in intent, so it wins
   always_comb
   begin
      value_next = value_reg;
      if (write_en)
      begin
         value_next = write_value;
      end
      else if (load_strap)
      begin
         value_next = strap_value;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         value_reg <= RESET_VALUE;
      end
      else
      begin
         value_reg <= value_next;
      end
   end

   assign value = value_reg;

   a_cell_write_lands: assert property (@(posedge clock) disable iff (rst)
      write_en |=> value == $past(write_value))
      else $error("written value not stored");
endmodule
`default_nettype wire

/* File: verilog/hub_cfg_pkg.sv */
`default_nettype none
package hub_cfg_pkg;
   // byte offsets of the configuration space
   localparam logic [7:0] SIGNATURE_OFFSET = 8'h00;
   localparam logic [7:0] PRODUCT_ID_HIGH_OFFSET = 8'h04;
   localparam logic [7:0] DEVICE_CONFIG_OFFSET = 8'h05;
   localparam logic [7:0] SIGNATURE_VALUE = 8'h55;
   // field positions of the device configuration byte
   localparam int LOAD_TEXT_BIT = 7;
   localparam int USER_SERIAL_BIT = 6;
   localparam int LINK_BLOCK_BIT = 5;
   localparam int PORT_INDICATOR_BIT = 4;
   localparam int GANGED_BIT = 3;
   localparam int POWER_CTRL_BIT = 2;
   localparam int RESERVED_HIGH_BIT = 1;
   localparam int RESERVED_LOW_BIT = 0;
   // values after reset
   localparam logic LOAD_TEXT_RESET = 1'b0;
   localparam logic LINK_BLOCK_RESET = 1'b0;
   localparam logic POWER_CTRL_RESET = 1'b0;
   localparam logic FIXED_ONE = 1'b1;
   localparam logic [1:0] RESERVED_VALUE = 2'h0;
   localparam logic [7:0] READ_ZERO = 8'h00;
   // identity byte: value is arbitrary
   localparam logic [7:0] PRODUCT_ID_HIGH_RESET = 8'h5A;
   typedef enum logic [1:0] {SIG_WAIT, SIG_VALID, SIG_INVALID} signature_t;
endpackage
`default_nettype wire

/* File: verilog/hub_device_config_regs.sv */
// Contract
// RQ1: product id high byte held at offset 4h, replaceable by eeprom or host.
// RQ2: bit 7 set in eeprom mode enables loading strings and language id.
// RQ3: bit 7 set in smbus mode lets host write strings and language id.
// RQ4: bit 6 always reads one; eeprom mode loads serial number.
// RQ5: smbus mode lets host write serial number registers.
// RQ6: bit 5 set blocks U1/U2 everywhere unless forcing LMP seen.
// RQ7: after forcing LMP, U1/U2 stay enabled until reset or upstream disconnect.
// RQ8: bit 5 takes serial data strap level at reset release.
// RQ9: bit 5 reloaded from eeprom, or overwritten by smbus host.
// RQ10: bits 4 and 3 always hold one; writers must not change them.
// RQ11: bit 2 from power strap at release, then eeprom or host.
// RQ12: bits 1:0 read-only, read zero.
// RQ13: eeprom loads only when byte 00h equals 55h, else defaults kept.
// RQ14: smbus mode waits for host done; no upstream connect before.
// RQ15: byte-wide access; overwrite only in eeprom or smbus mode.
`timescale 1ns/1ps
`default_nettype none
module hub_device_config_regs
(
   input wire logic clock,
   input wire logic rst,
   input wire logic eeprom_mode,
   input wire logic smbus_mode,
   input wire logic serial_data_strap_pin,
   input wire logic power_mgmt_address_strap_pin,
   input wire logic eeprom_wr_en,
   input wire logic smbus_wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_addr,
   input wire logic force_lpm_event,
   input wire logic upstream_disconnect,
   input wire logic eeprom_load_done,
   input wire logic host_cfg_done,
   output logic [7:0] rd_data,
   output logic [7:0] product_id_high_byte,
   output logic load_user_text_enable,
   output logic user_serial_enable,
   output logic low_power_link_state_block,
   output logic port_indicator_setting,
   output logic ganged_power_setting,
   output logic per_port_power_control_n,
   output logic u1u2_permitted,
   output logic string_eeprom_load,
   output logic string_host_write,
   output logic serial_eeprom_load,
   output logic serial_host_write,
   output logic signature_valid,
   output logic upstream_connect_allow
);
   hub_cfg_pkg::signature_t sig_reg;
   hub_cfg_pkg::signature_t sig_next;
   logic sig_valid_reg;
   logic sig_valid_next;
   logic strap_pending_reg;
   logic cfg_done_reg;
   logic cfg_done_next;
   logic forced_reg;
   logic forced_next;
   logic fixed_reg;
   logic [7:0] rd_data_reg;
   logic [7:0] rd_data_next;
   logic [4:0] perm_reg;
   logic [4:0] perm_next;
   logic eeprom_ok;
   logic smbus_ok;
   logic wr_ok;
   logic product_write;
   logic config_write;
   logic [7:0] config_byte;

   // eeprom data counts only once the signature checked out
   assign eeprom_ok = eeprom_mode && eeprom_wr_en && !cfg_done_reg
      && sig_reg == hub_cfg_pkg::SIG_VALID; // RQ13
   assign smbus_ok = smbus_mode && smbus_wr_en;
   // no mode, no overwrite
   assign wr_ok = eeprom_ok || smbus_ok; // RQ15
   assign product_write = wr_ok
      && wr_addr == hub_cfg_pkg::PRODUCT_ID_HIGH_OFFSET; // RQ1
   assign config_write = wr_ok
      && wr_addr == hub_cfg_pkg::DEVICE_CONFIG_OFFSET;

   config_field_cell #(.WIDTH(8),
      .RESET_VALUE(hub_cfg_pkg::PRODUCT_ID_HIGH_RESET)) product_cell
   (
      .clock(clock),
      .rst(rst),
      .load_strap(1'b0),
      .strap_value(hub_cfg_pkg::PRODUCT_ID_HIGH_RESET),
      .write_en(product_write), // RQ1
      .write_value(wr_data),
      .value(product_id_high_byte)
   );

   config_field_cell #(.WIDTH(1),
      .RESET_VALUE(hub_cfg_pkg::LOAD_TEXT_RESET)) text_cell
   (
      .clock(clock),
      .rst(rst),
      .load_strap(1'b0),
      .strap_value(hub_cfg_pkg::LOAD_TEXT_RESET),
      .write_en(config_write),
      .write_value(wr_data[hub_cfg_pkg::LOAD_TEXT_BIT]),
      .value(load_user_text_enable)
   );

   config_field_cell #(.WIDTH(1),
      .RESET_VALUE(hub_cfg_pkg::LINK_BLOCK_RESET)) link_cell
   (
      .clock(clock),
      .rst(rst),
      .load_strap(strap_pending_reg), // RQ8
      .strap_value(serial_data_strap_pin),
      .write_en(config_write), // RQ9
      .write_value(wr_data[hub_cfg_pkg::LINK_BLOCK_BIT]),
      .value(low_power_link_state_block)
   );

   config_field_cell #(.WIDTH(1),
      .RESET_VALUE(hub_cfg_pkg::POWER_CTRL_RESET)) power_cell
   (
      .clock(clock),
      .rst(rst),
      .load_strap(strap_pending_reg), // RQ11
      .strap_value(power_mgmt_address_strap_pin),
      .write_en(config_write), // RQ11
      .write_value(wr_data[hub_cfg_pkg::POWER_CTRL_BIT]),
      .value(per_port_power_control_n)
   );

   always_comb
   begin
      config_byte = hub_cfg_pkg::READ_ZERO;
      config_byte[hub_cfg_pkg::LOAD_TEXT_BIT] = load_user_text_enable;
      config_byte[hub_cfg_pkg::USER_SERIAL_BIT] = fixed_reg; // RQ4
      config_byte[hub_cfg_pkg::LINK_BLOCK_BIT] = low_power_link_state_block;
      config_byte[hub_cfg_pkg::PORT_INDICATOR_BIT] = fixed_reg; // RQ10
      config_byte[hub_cfg_pkg::GANGED_BIT] = fixed_reg; // RQ10
      config_byte[hub_cfg_pkg::POWER_CTRL_BIT] = per_port_power_control_n;
      config_byte[hub_cfg_pkg::RESERVED_HIGH_BIT:
         hub_cfg_pkg::RESERVED_LOW_BIT] = hub_cfg_pkg::RESERVED_VALUE; // RQ12
   end

   always_comb
   begin
      sig_next = sig_reg;
      if (sig_reg == hub_cfg_pkg::SIG_WAIT && eeprom_mode && eeprom_wr_en
         && wr_addr == hub_cfg_pkg::SIGNATURE_OFFSET)
      begin
         if (wr_data == hub_cfg_pkg::SIGNATURE_VALUE)
         begin
            sig_next = hub_cfg_pkg::SIG_VALID;
         end
         else
         begin
            sig_next = hub_cfg_pkg::SIG_INVALID; // RQ13
         end
      end
      // kept in its own flop so the output needs no decode after the state
      sig_valid_next = sig_next == hub_cfg_pkg::SIG_VALID; // RQ13
      // a bad signature ends the load one cycle after the state turns invalid, defaults stay
      cfg_done_next = cfg_done_reg
         || (!eeprom_mode && !smbus_mode)
         || (eeprom_mode && (eeprom_load_done
            || sig_reg == hub_cfg_pkg::SIG_INVALID))
         || (smbus_mode && host_cfg_done); // RQ14
      // the event beats a disconnect in the same cycle
      forced_next = forced_reg;
      if (force_lpm_event)
      begin
         forced_next = 1'b1; // RQ7
      end
      else if (upstream_disconnect)
      begin
         forced_next = 1'b0; // RQ7
      end
      perm_next[0] = eeprom_mode && load_user_text_enable; // RQ2
      perm_next[1] = smbus_mode && load_user_text_enable; // RQ3
      perm_next[2] = eeprom_mode && fixed_reg; // RQ4
      perm_next[3] = smbus_mode && fixed_reg; // RQ5
      perm_next[4] = !low_power_link_state_block || forced_next; // RQ6
      case (rd_addr)
         hub_cfg_pkg::PRODUCT_ID_HIGH_OFFSET:
            rd_data_next = product_id_high_byte;
         hub_cfg_pkg::DEVICE_CONFIG_OFFSET:
            rd_data_next = config_byte;
         default:
            rd_data_next = hub_cfg_pkg::READ_ZERO;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         sig_reg <= hub_cfg_pkg::SIG_WAIT;
         sig_valid_reg <= 1'b0;
         strap_pending_reg <= 1'b1;
         cfg_done_reg <= 1'b0;
         forced_reg <= 1'b0;
         fixed_reg <= hub_cfg_pkg::FIXED_ONE;
         perm_reg <= 5'h00;
         rd_data_reg <= hub_cfg_pkg::READ_ZERO;
      end
      else
      begin
         sig_reg <= sig_next;
         sig_valid_reg <= sig_valid_next;
         strap_pending_reg <= 1'b0;
         cfg_done_reg <= cfg_done_next;
         forced_reg <= forced_next;
         fixed_reg <= hub_cfg_pkg::FIXED_ONE;
         perm_reg <= perm_next;
         rd_data_reg <= rd_data_next;
      end
   end

   assign rd_data = rd_data_reg;
   assign user_serial_enable = fixed_reg;
   assign port_indicator_setting = fixed_reg;
   assign ganged_power_setting = fixed_reg;
   assign string_eeprom_load = perm_reg[0];
   assign string_host_write = perm_reg[1];
   assign serial_eeprom_load = perm_reg[2];
   assign serial_host_write = perm_reg[3];
   assign u1u2_permitted = perm_reg[4];
   assign signature_valid = sig_valid_reg;
   assign upstream_connect_allow = cfg_done_reg;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence s_config_read;
      rd_addr == hub_cfg_pkg::DEVICE_CONFIG_OFFSET;
   endsequence

   sequence s_forced_kept;
      force_lpm_event ##1 (!upstream_disconnect)[*3];
   endsequence

   a_product_write_lands: assert property (product_write |=>
      product_id_high_byte == $past(wr_data)) // RQ1
      else $error("product byte write lost");
   a_bad_sig_blocks: assert property (eeprom_mode && !smbus_ok
      && sig_reg != hub_cfg_pkg::SIG_VALID |=> $stable(product_id_high_byte))
      else $error("eeprom load without valid signature"); // RQ13
   a_no_mode_stable: assert property (!eeprom_mode && !smbus_mode
      |=> $stable(product_id_high_byte) && $stable(load_user_text_enable))
      else $error("register changed outside a load mode"); // RQ15
   a_serial_fixed_one: assert property (s_config_read |=>
      rd_data[hub_cfg_pkg::USER_SERIAL_BIT] == 1'b1) // RQ4
      else $error("user serial bit not one");
   a_fixed_ones_read: assert property (s_config_read |=>
      rd_data[4:3] == 2'h3) // RQ10
      else $error("indicator or ganged bit not one");
   a_reserved_zero: assert property (s_config_read |=>
      rd_data[1:0] == 2'h0) // RQ12
      else $error("reserved bits not zero");
   a_link_strap_load: assert property (strap_pending_reg && !config_write
      |=> low_power_link_state_block == $past(serial_data_strap_pin))
      else $error("link block strap not caught"); // RQ8
   a_power_strap_load: assert property (strap_pending_reg && !config_write
      |=> per_port_power_control_n == $past(power_mgmt_address_strap_pin))
      else $error("power strap not caught"); // RQ11
   a_link_host_write: assert property (config_write |=>
      low_power_link_state_block == $past(wr_data[5])) // RQ9
      else $error("link block write lost");
   a_link_blocked: assert property (low_power_link_state_block && !forced_reg
      && !force_lpm_event |=> !u1u2_permitted) // RQ6
      else $error("low power states allowed while blocked");
   a_forced_hold: assert property (s_forced_kept |-> u1u2_permitted)
      else $error("forced low power permission dropped"); // RQ7
   a_text_perms: assert property (load_user_text_enable |=>
      string_eeprom_load == $past(eeprom_mode)
      && string_host_write == $past(smbus_mode)) // RQ2 RQ3
      else $error("string permission wrong");
   a_serial_perms: assert property (1'b1 |=> serial_host_write
      == $past(smbus_mode)) // RQ5
      else $error("serial host permission wrong");
   a_wait_for_host: assert property (smbus_mode && !eeprom_mode
      && !cfg_done_reg && !host_cfg_done |=> !upstream_connect_allow)
      else $error("connect before host finished"); // RQ14
endmodule
`default_nettype wire
